// >>> logic/vpi_core.sv
// Vectored priority interrupt and trap controller with its register file.
`timescale 1ns/100ps
`include "vpi_consts.svh"

// Functional notes
// - User request n uses vector n plus eight.
// - Eight trap vectors below user vectors.
// - Control, flag, enable, priority, pending registers.
// - Control one: nesting disable and trap bits.
// - Control two: edge polarity, alternate table.
// - Hardware sets flags; software write clears.
// - Disabled sources never reach the core.
// - Each source has a 3-bit priority.
// - Pending register holds vector and level.
// - Bit positions follow request number order.
// - Status word bits 7:5 hold level.
// - Software cannot set the top level bit.
// - Low bits 111 block all user requests.
// - Top bit set blocks every user request.
// - Top bit reads one above level seven.
// - Nesting disable blocks software writes to low level bits.
// - Alternate select moves every vector fetch.
// - Equal priority: lower vector number wins.
// - Nesting disable stops user requests pre-empting handlers.
module vpi_core #(
    parameter int NUM_SRC = `VPI_NUM_SRC
) (
    input  wire logic              clk_i,
    input  wire logic              reset_i,
    input  wire vpi_pkg::vpi_bus_s bus_i,
    output logic [15:0]            rdata_o,
    input  wire logic [NUM_SRC-1:0] req_i,
    input  wire logic [4:0]        ext_int_i,
    input  wire logic [7:0]        trap_i,
    input  wire logic              disi_active_i,
    input  wire logic              ack_i,
    input  wire logic              restore_i,
    input  wire vpi_pkg::vpi_level_t restore_level_i,
    output vpi_pkg::vpi_irq_s      irq_o,
    output vpi_pkg::vpi_level_t    cpu_level_o
);
    import vpi_pkg::*;

    localparam int UIW = $clog2(NUM_SRC);
    localparam int EXT_REQ [5] = '{`VPI_EXT0_REQ, `VPI_EXT1_REQ,
                                   `VPI_EXT2_REQ, `VPI_EXT3_REQ,
                                   `VPI_EXT4_REQ};

    // ********************
    // State
    // ********************
    logic [15:0]        gc1_r;
    logic [15:0]        gc1_nxt;
    logic               alt_r;
    logic [4:0]         edge_pol_r;
    logic [4:0]         ext_prev_r;
    logic [NUM_SRC-1:0] flag_r;
    logic [NUM_SRC-1:0] flag_nxt;
    logic [NUM_SRC-1:0] en_r;
    logic [NUM_SRC-1:0] en_nxt;
    logic [2:0]         prio_r [NUM_SRC];
    logic [2:0]         ipl_low_r;
    logic               ipl_top_r;
    vpi_irq_s           irq_r;
    vpi_irq_s           irq_nxt;
    logic [15:0]        rdata_r;
    logic [15:0]        rdata_nxt;

    // ********************
    // Register decode
    // ********************
    logic [5:0] flag_idx;
    logic [5:0] en_idx;
    logic [5:0] prio_idx;
    logic       flag_hit;
    logic       en_hit;
    logic       prio_hit;
    logic       gc1_wr;
    logic       gc2_wr;
    logic       status_wr;
    logic       core_wr;
    logic       nest_dis;

    // Group offsets wrap below their base, so one compare decodes each.
    assign flag_idx  = bus_i.addr - `VPI_OFF_FLAG;
    assign en_idx    = bus_i.addr - `VPI_OFF_EN;
    assign prio_idx  = bus_i.addr - `VPI_OFF_PRIO;
    assign flag_hit  = flag_idx < `VPI_NUM_FLAG_REGS;
    assign en_hit    = en_idx < `VPI_NUM_FLAG_REGS;
    assign prio_hit  = prio_idx < `VPI_NUM_PRIO_REGS;
    assign gc1_wr    = bus_i.wr && bus_i.addr == `VPI_OFF_GC1;
    assign gc2_wr    = bus_i.wr && bus_i.addr == `VPI_OFF_GC2;
    assign status_wr = bus_i.wr && bus_i.addr == `VPI_OFF_STATUS;
    assign core_wr   = bus_i.wr && bus_i.addr == `VPI_OFF_CORE;
    assign nest_dis  = gc1_r[`VPI_GC1_NSTD_BIT];

    // ********************
    // External request edge detect
    // ********************
    logic [4:0]         ext_edge;
    logic [NUM_SRC-1:0] set_vec;

    // Polarity bit high selects the falling edge. A pin already high
    // out of reset looks like a rising edge on the first cycle.
    assign ext_edge = (edge_pol_r & ext_prev_r & ~ext_int_i)
                    | (~edge_pol_r & ~ext_prev_r & ext_int_i);

    // Peripheral pulses and pin edges are the only hardware flag set sources.
    always_comb begin
        set_vec = req_i;
        for (int j = 0; j < 5; j++) begin
            set_vec[EXT_REQ[j]] = set_vec[EXT_REQ[j]] | ext_edge[j];
        end
    end

    // ********************
    // Flag and enable next values
    // ********************
    // Bit i of the flat vector lives in group i/16, bit i%16.
    // A set in the same cycle as a clearing write wins, so no request is
    // lost while software acknowledges an older one.
    always_comb begin
        flag_nxt = flag_r;
        en_nxt   = en_r;
        for (int i = 0; i < NUM_SRC; i++) begin
            if (bus_i.wr && flag_hit && flag_idx == 6'(i / 16)) begin
                flag_nxt[i] = bus_i.wdata[i % 16];
            end
            if (bus_i.wr && en_hit && en_idx == 6'(i / 16)) begin
                en_nxt[i] = bus_i.wdata[i % 16];
            end
        end
        flag_nxt = flag_nxt | set_vec;
    end

    // Trap status bits are set by hardware over any clearing write.
    always_comb begin
        gc1_nxt = gc1_r;
        if (gc1_wr) begin
            gc1_nxt = bus_i.wdata & `VPI_GC1_WMASK;
        end
        gc1_nxt[`VPI_TRAP_OSC_BIT]  = gc1_nxt[`VPI_TRAP_OSC_BIT]  | trap_i[1];
        gc1_nxt[`VPI_TRAP_ADDR_BIT] = gc1_nxt[`VPI_TRAP_ADDR_BIT] | trap_i[2];
        gc1_nxt[`VPI_TRAP_STK_BIT]  = gc1_nxt[`VPI_TRAP_STK_BIT]  | trap_i[3];
        gc1_nxt[`VPI_TRAP_MATH_BIT] = gc1_nxt[`VPI_TRAP_MATH_BIT] | trap_i[4];
        gc1_nxt[`VPI_TRAP_DMA_BIT]  = gc1_nxt[`VPI_TRAP_DMA_BIT]  | trap_i[5];
    end

    // ********************
    // Eligibility of user requests and traps
    // ********************
    vpi_level_t          cpu_level;
    logic [NUM_SRC-1:0]  user_ok;
    logic [NUM_SRC*4-1:0] user_lvls;
    logic [7:0]          trap_flag;
    logic [7:0]          trap_ok;
    logic [31:0]         trap_lvls;

    assign cpu_level = {ipl_top_r, ipl_low_r};

    // Level 7 or any level with the top bit set is never exceeded by a
    // 3-bit priority, which blocks all user requests there.
    for (genvar i = 0; i < NUM_SRC; i++) begin : g_user
        assign user_ok[i] = flag_r[i] & en_r[i] & ~ipl_top_r
                          & (prio_r[i] != 3'h0)
                          & ({1'b0, prio_r[i]} > cpu_level);
        assign user_lvls[i*4 +: 4] = {1'b0, prio_r[i]};
    end

    // Reserved trap vectors 0, 6 and 7 have no source and never flag.
    assign trap_flag = {2'b00,
                        gc1_r[`VPI_TRAP_DMA_BIT],
                        gc1_r[`VPI_TRAP_MATH_BIT],
                        gc1_r[`VPI_TRAP_STK_BIT],
                        gc1_r[`VPI_TRAP_ADDR_BIT],
                        gc1_r[`VPI_TRAP_OSC_BIT],
                        1'b0};
    assign trap_lvls = `VPI_TRAP_LEVELS;

    for (genvar t = 0; t < 8; t++) begin : g_trap
        assign trap_ok[t] = trap_flag[t]
                          & (trap_lvls[t*4 +: 4] > cpu_level);
    end

    // ********************
    // Arbitration
    // ********************
    logic           user_any;
    logic [UIW-1:0] user_idx;
    vpi_level_t     user_lvl;
    logic           trap_any;
    logic [2:0]     trap_idx;
    vpi_level_t     trap_lvl;
    logic [6:0]     pend_vec;
    vpi_level_t     pend_lvl;

    vpi_pick #(
        .N  (NUM_SRC),
        .LW (4),
        .IW (UIW)
    ) u_user_pick (
        .valid_i (user_ok),
        .lvl_i   (user_lvls),
        .any_o   (user_any),
        .idx_o   (user_idx),
        .lvl_o   (user_lvl)
    );

    vpi_pick #(
        .N  (8),
        .LW (4),
        .IW (3)
    ) u_trap_pick (
        .valid_i (trap_ok),
        .lvl_i   (trap_lvls),
        .any_o   (trap_any),
        .idx_o   (trap_idx),
        .lvl_o   (trap_lvl)
    );

    // Traps sit above every user level, so any eligible trap wins.
    assign pend_vec = trap_any ? {4'h0, trap_idx}
                               : 7'(user_idx) + `VPI_USER_VEC_OFS;
    assign pend_lvl = trap_any ? trap_lvl : user_lvl;

    // Vector word sits two bytes per vector above the table base.
    always_comb begin
        irq_nxt.valid  = trap_any | user_any;
        irq_nxt.vector = irq_nxt.valid ? pend_vec : 7'h00;
        irq_nxt.level  = irq_nxt.valid ? pend_lvl : 4'h0;
        irq_nxt.addr   = `VPI_IVT_BASE + {16'h0000, irq_nxt.vector, 1'b0}
                       + (alt_r ? `VPI_ALT_OFS : 24'h000000);
    end

    // ********************
    // Read data
    // ********************
    logic [15:0] flag_word;
    logic [15:0] en_word;
    logic [15:0] prio_word;

    // Slices beyond the last source read as zero.
    always_comb begin
        int k;
        k = 0;
        flag_word = 16'h0000;
        en_word   = 16'h0000;
        prio_word = 16'h0000;
        for (int b = 0; b < 16; b++) begin
            k = int'(flag_idx) * 16 + b;
            if (k < NUM_SRC) flag_word[b] = flag_r[k];
            k = int'(en_idx) * 16 + b;
            if (k < NUM_SRC) en_word[b] = en_r[k];
        end
        for (int j = 0; j < `VPI_SRC_PER_PRIO; j++) begin
            k = int'(prio_idx) * `VPI_SRC_PER_PRIO + j;
            if (k < NUM_SRC) begin
                prio_word[j*`VPI_PRIO_FIELD_W +: 3] = prio_r[k];
            end
        end
    end

    // Unmapped offsets read as zero.
    always_comb begin
        rdata_nxt = 16'h0000;
        if (flag_hit) begin
            rdata_nxt = flag_word;
        end else if (en_hit) begin
            rdata_nxt = en_word;
        end else if (prio_hit) begin
            rdata_nxt = prio_word;
        end else begin
            unique case (bus_i.addr)
                `VPI_OFF_GC1:    rdata_nxt = gc1_r;
                `VPI_OFF_GC2:    rdata_nxt = {alt_r, disi_active_i, 9'h000,
                                              edge_pol_r};
                `VPI_OFF_PEND:   rdata_nxt = {4'h0, irq_r.level, 1'b0,
                                              irq_r.vector};
                `VPI_OFF_STATUS: rdata_nxt = {8'h00, ipl_low_r, 5'h00};
                `VPI_OFF_CORE:   rdata_nxt = {12'h000, ipl_top_r,
                                              3'h0};
                default:         rdata_nxt = 16'h0000;
            endcase
        end
    end

    // ********************
    // Registers
    // ********************
    // Everything here clears on reset; the primary table is selected.
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            gc1_r      <= `VPI_GC1_RST;
            alt_r      <= 1'b0;
            edge_pol_r <= 5'h00;
            ext_prev_r <= 5'h00;
            flag_r     <= '0;
            en_r       <= '0;
            irq_r      <= '0;
            rdata_r    <= 16'h0000;
        end else begin
            gc1_r      <= gc1_nxt;
            ext_prev_r <= ext_int_i;
            flag_r     <= flag_nxt;
            en_r       <= en_nxt;
            irq_r      <= irq_nxt;
            rdata_r    <= bus_i.rd ? rdata_nxt : 16'h0000;
            if (gc2_wr) begin
                alt_r      <= bus_i.wdata[`VPI_GC2_ALT_BIT];
                edge_pol_r <= bus_i.wdata[`VPI_GC2_EP_W-1:0];
            end
        end
    end

    // Each source owns one field of four bits in its priority group.
    always_ff @(posedge clk_i) begin
        for (int i = 0; i < NUM_SRC; i++) begin
            if (reset_i) begin
                prio_r[i] <= 3'h0;
            end else if (bus_i.wr && prio_hit
                         && prio_idx == 6'(i / `VPI_SRC_PER_PRIO)) begin
                prio_r[i] <= bus_i.wdata[(i % `VPI_SRC_PER_PRIO)
                                         * `VPI_PRIO_FIELD_W +: 3];
            end
        end
    end

    // Acceptance raises the level to the taken request; with nesting off
    // a user handler runs at 7 so no user request can pre-empt it. The
    // core's own accept and return win over a software write that cycle.
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            {ipl_top_r, ipl_low_r} <= `VPI_LEVEL_RST;
        end else if (ack_i && irq_r.valid) begin
            if (nest_dis && !irq_r.level[3]) begin
                {ipl_top_r, ipl_low_r} <= {1'b0, `VPI_NEST_LEVEL};
            end else begin
                {ipl_top_r, ipl_low_r} <= irq_r.level;
            end
        end else if (restore_i) begin
            {ipl_top_r, ipl_low_r} <= restore_level_i;
        end else begin
            if (status_wr && !nest_dis) begin
                ipl_low_r <= bus_i.wdata[`VPI_STATUS_IPL_LSB +: 3];
            end
            if (core_wr && !bus_i.wdata[`VPI_CORE_CPU_LEVEL_TOP_BIT_BIT]) begin
                ipl_top_r <= 1'b0;
            end
        end
    end

    // ********************
    // Outputs
    // ********************
    assign rdata_o     = rdata_r;
    assign irq_o       = irq_r;
    assign cpu_level_o = cpu_level;

endmodule : vpi_core

// >>> logic/vpi_consts.svh
// Offsets, field positions, reset values and counts of the controller.
`ifndef VPI_CONSTS_SVH
`define VPI_CONSTS_SVH

// ********************
// Register word offsets on the plain register port
// ********************
`define VPI_OFF_GC1          6'h00
`define VPI_OFF_GC2          6'h01
`define VPI_OFF_FLAG         6'h02
`define VPI_OFF_EN           6'h07
`define VPI_OFF_PRIO         6'h0c
`define VPI_OFF_PEND         6'h1e
`define VPI_OFF_STATUS       6'h1f
`define VPI_OFF_CORE         6'h20

// ********************
// Group sizes
// ********************
`define VPI_NUM_SRC          72
`define VPI_NUM_FLAG_REGS    6'h05
`define VPI_NUM_PRIO_REGS    6'h12
`define VPI_SRC_PER_PRIO     4
`define VPI_PRIO_FIELD_W     4

// ********************
// Field positions
// ********************
`define VPI_GC1_NSTD_BIT     15
`define VPI_GC1_WMASK        16'hfffe
`define VPI_TRAP_OSC_BIT     1
`define VPI_TRAP_STK_BIT     2
`define VPI_TRAP_ADDR_BIT    3
`define VPI_TRAP_MATH_BIT    4
`define VPI_TRAP_DMA_BIT     5
`define VPI_GC2_ALT_BIT      15
`define VPI_GC2_DISI_BIT     14
`define VPI_GC2_EP_W         5
`define VPI_STATUS_IPL_LSB   5
`define VPI_CORE_CPU_LEVEL_TOP_BIT_BIT    3
`define VPI_PEND_LVL_LSB     8

// ********************
// External request numbers, vector layout and fixed levels
// ********************
`define VPI_EXT0_REQ         0
`define VPI_EXT1_REQ         20
`define VPI_EXT2_REQ         29
`define VPI_EXT3_REQ         53
`define VPI_EXT4_REQ         54
`define VPI_USER_VEC_OFS     7'h08
`define VPI_IVT_BASE         24'h000004
`define VPI_ALT_OFS          24'h000100
`define VPI_NEST_LEVEL       3'h7
`define VPI_TRAP_LEVELS      32'h89abcdef
`define VPI_GC1_RST          16'h0000
`define VPI_LEVEL_RST        4'h0

`endif

// >>> logic/vpi_pkg.sv
// Types shared by the vectored interrupt controller files.
package vpi_pkg;

    // Register port request, one cycle per strobe.
    typedef struct packed {
        logic [5:0]  addr;
        logic [15:0] wdata;
        logic        wr;
        logic        rd;
    } vpi_bus_s;

    // Pending interrupt presented to the core.
    typedef struct packed {
        logic        valid;
        logic [6:0]  vector;
        logic [3:0]  level;
        logic [23:0] addr;
    } vpi_irq_s;

    typedef logic [3:0] vpi_level_t;

endpackage : vpi_pkg

// >>> logic/vpi_pick.sv
// Highest-level picker with lowest-index tie break.
`timescale 1ns/100ps

module vpi_pick #(
    parameter int N  = 8,
    parameter int LW = 4,
    parameter int IW = (N > 1) ? $clog2(N) : 1
) (
    input  wire logic [N-1:0]    valid_i,
    input  wire logic [N*LW-1:0] lvl_i,
    output logic                 any_o,
    output logic [IW-1:0]        idx_o,
    output logic [LW-1:0]        lvl_o
);

    // Scan upward and replace only on a strictly higher level, so the
    // lower index keeps an equal-level tie.
    always_comb begin
        any_o = 1'b0;
        idx_o = '0;
        lvl_o = '0;
        for (int i = 0; i < N; i++) begin
            if (valid_i[i] && (!any_o || lvl_i[i*LW +: LW] > lvl_o)) begin
                any_o = 1'b1;
                idx_o = IW'(i);
                lvl_o = lvl_i[i*LW +: LW];
            end
        end
    end

endmodule : vpi_pick

// >>> verif/vpi_core_chk.sv
// Checker of the vectored interrupt controller, bound to its top module.
`timescale 1ns/100ps
`include "vpi_consts.svh"

module vpi_core_chk #(
    parameter int NUM_SRC = `VPI_NUM_SRC
) (
    input wire logic                clk_i,
    input wire logic                reset_i,
    input wire vpi_pkg::vpi_bus_s   bus_i,
    input wire logic [15:0]         rdata_o,
    input wire logic [NUM_SRC-1:0]  req_i,
    input wire logic [4:0]          ext_int_i,
    input wire logic [7:0]          trap_i,
    input wire logic                disi_active_i,
    input wire logic                ack_i,
    input wire logic                restore_i,
    input wire vpi_pkg::vpi_level_t restore_level_i,
    input wire vpi_pkg::vpi_irq_s   irq_o,
    input wire vpi_pkg::vpi_level_t cpu_level_o
);
    import vpi_pkg::*;
    // ********************
    // Helper state
    // ********************
    logic nstd_r;
    logic st_wr;
    logic took;

    // Shadow of nesting disable, so level writes can be judged.
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            nstd_r <= 1'b0;
        end else if (bus_i.wr && bus_i.addr == `VPI_OFF_GC1) begin
            nstd_r <= bus_i.wdata[`VPI_GC1_NSTD_BIT];
        end
    end

    // A status write counts only when no core event overrides it.
    assign st_wr = bus_i.wr && bus_i.addr == `VPI_OFF_STATUS &&
                   !(ack_i && irq_o.valid) && !restore_i;
    assign took  = ack_i && irq_o.valid;

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (reset_i);

    // ********************
    // Assertions
    // ********************
    vec_addr_a: assert property (
        irq_o.valid |-> irq_o.addr[23:9] == 0 &&
        irq_o.addr[7:0] == 8'h04 + {irq_o.vector, 1'b0})
        else $error("vector address wrong");
    trap_lvl_a: assert property (
        irq_o.valid && irq_o.vector < 7'd8 |->
        irq_o.level[3] && irq_o.vector inside {[7'd1:7'd5]})
        else $error("trap level wrong");
    user_lvl_a: assert property (
        irq_o.valid && irq_o.vector >= 7'd8 |->
        irq_o.level > $past(cpu_level_o) && irq_o.level != 4'h0)
        else $error("user request not above level");
    top_set_a: assert property ($rose(cpu_level_o[3]) |->
        $past(took) || $past(restore_i))
        else $error("top level bit set by software");
    nest_hold_a: assert property (
        st_wr && nstd_r |=> $stable(cpu_level_o))
        else $error("level changed under nesting disable");
    lvl_write_a: assert property (st_wr && !nstd_r |=>
        cpu_level_o[2:0] == $past(bus_i.wdata[7:5]))
        else $error("level write lost");
    ack_lvl_a: assert property (took |=> cpu_level_o ==
        (($past(nstd_r) && $past(irq_o.vector) >= 7'd8) ? 4'h7
         : $past(irq_o.level)))
        else $error("level after accept wrong");
    core_rd_a: assert property (
        bus_i.rd && bus_i.addr == `VPI_OFF_CORE |=>
        rdata_o == {12'h000, $past(cpu_level_o[3]), 3'h0})
        else $error("core control read wrong");

    // Main scenarios reached.
    cover property (took && irq_o.vector >= 7'd8);
    cover property (took && irq_o.vector < 7'd8);
    cover property (restore_i);
endmodule : vpi_core_chk

bind vpi_core vpi_core_chk #(.NUM_SRC(NUM_SRC)) chk_u (
    .clk_i(clk_i), .reset_i(reset_i), .bus_i(bus_i), .rdata_o(rdata_o),
    .req_i(req_i), .ext_int_i(ext_int_i), .trap_i(trap_i),
    .disi_active_i(disi_active_i), .ack_i(ack_i), .restore_i(restore_i),
    .restore_level_i(restore_level_i), .irq_o(irq_o),
    .cpu_level_o(cpu_level_o));

// >>> verif/vpi_cpu_model.sv
// Behavioural model of the core that accepts and returns from interrupts.
`timescale 1ns/100ps

module vpi_cpu_model (
    input  wire logic                clk_i,
    input  wire logic                reset_i,
    input  wire vpi_pkg::vpi_irq_s   irq_i,
    input  wire vpi_pkg::vpi_level_t level_i,
    input  wire logic                take_i,
    input  wire logic [3:0]          wait_i,
    input  wire logic                ret_i,
    output logic                     ack_o,
    output logic                     restore_o,
    output vpi_pkg::vpi_level_t      restore_level_o,
    output logic [6:0]               fetch_vec_o
);
    import vpi_pkg::*;
    logic [3:0] cnt_r;
    logic       armed_r;
    vpi_level_t saved_r;

    // One accept per arming, so a slow clear of valid is never taken twice.
    // The level held before the accept is kept for the return.
    always_ff @(posedge clk_i) begin
        ack_o <= 1'b0;
        restore_o <= 1'b0;
        if (reset_i) begin
            cnt_r <= 4'h0;
            armed_r <= 1'b0;
            saved_r <= 4'h0;
            restore_level_o <= 4'h0;
            fetch_vec_o <= 7'h00;
        end else if (ret_i) begin
            restore_o <= 1'b1;
            restore_level_o <= saved_r;
        end else if (take_i) begin
            armed_r <= 1'b1;
            cnt_r <= 4'h0;
        end else if (armed_r && irq_i.valid) begin
            if (cnt_r == wait_i) begin
                ack_o <= 1'b1;
                armed_r <= 1'b0;
                saved_r <= level_i;
                fetch_vec_o <= irq_i.vector;
            end else begin
                cnt_r <= cnt_r + 4'h1;
            end
        end
    end
endmodule : vpi_cpu_model

// >>> verif/tb_top.sv
// Self-checking testbench of the vectored interrupt controller.
`timescale 1ns/100ps
`include "vpi_consts.svh"

module tb_top;
    import vpi_pkg::*;
    logic        clk_i;
    logic        reset_i;
    vpi_bus_s    bus;
    logic [15:0] rdata;
    logic [71:0] req;
    logic [4:0]  ext;
    logic [7:0]  trap;
    logic        disi;
    logic        ack;
    logic        rsto;
    vpi_level_t  rlvl;
    vpi_irq_s    irq;
    vpi_level_t  lvl;
    logic        take;
    logic [3:0]  wait_n;
    logic        ret;
    logic [6:0]  f_vec;
    int          n_errors;
    int          checks_done;
    int          cyc;
    logic [5:0]  rst_addr [9] = '{6'h00, 6'h01, 6'h02, 6'h07, 6'h0c,
                                  6'h1e, 6'h1f, 6'h20, 6'h3f};

    vpi_core dut_u (.clk_i(clk_i), .reset_i(reset_i), .bus_i(bus),
        .rdata_o(rdata), .req_i(req), .ext_int_i(ext), .trap_i(trap),
        .disi_active_i(disi), .ack_i(ack), .restore_i(rsto),
        .restore_level_i(rlvl), .irq_o(irq), .cpu_level_o(lvl));
    vpi_cpu_model cpu_u (.clk_i(clk_i), .reset_i(reset_i), .irq_i(irq),
        .level_i(lvl), .take_i(take), .wait_i(wait_n), .ret_i(ret),
        .ack_o(ack), .restore_o(rsto), .restore_level_o(rlvl),
        .fetch_vec_o(f_vec));

    // ********************
    // Clock and hang guard
    // ********************
    initial begin
        clk_i = 1'b0;
        forever #4 clk_i = ~clk_i;
    end
    // The whole run needs well under a thousand cycles.
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 20000) begin
            n_errors++;
            report_and_stop();
        end
    end

    // ********************
    // Tasks
    // ********************
    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        checks_done++;
        if (got !== exp) begin
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
            n_errors++;
        end
    endtask : chk
    task automatic wr(input logic [5:0] a, input logic [15:0] d);
        @(posedge clk_i);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk_i);
        bus.wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [5:0] a, input logic [15:0] e);
        @(posedge clk_i);
        bus <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
        @(posedge clk_i);
        bus.rd <= 1'b0;
        #1;
        chk({8'h00, rdata}, {8'h00, e});
    endtask : rd
    task automatic pulse_req(input int n);
        @(posedge clk_i);
        req[n] <= 1'b1;
        @(posedge clk_i);
        req[n] <= 1'b0;
    endtask : pulse_req
    task automatic wait_irq(input logic v);
        int i;
        i = 0;
        #1;
        while (irq.valid !== v && i < 20) begin
            @(posedge clk_i);
            #1;
            i++;
        end
        chk({23'h0, irq.valid}, {23'h0, v});
    endtask : wait_irq
    // Arm the core model, then wait for the request to be taken.
    task automatic grab(input logic [3:0] w);
        @(posedge clk_i);
        take <= 1'b1;
        wait_n <= w;
        @(posedge clk_i);
        take <= 1'b0;
        wait_irq(1'b0);
    endtask : grab
    task automatic give_back(input vpi_level_t e);
        @(posedge clk_i);
        ret <= 1'b1;
        @(posedge clk_i);
        ret <= 1'b0;
        repeat (2) @(posedge clk_i);
        #1;
        chk({20'h0, lvl}, {20'h0, e});
    endtask : give_back
    task automatic report_and_stop;
        if (n_errors == 0 && checks_done > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : report_and_stop

    // ********************
    // Scenarios
    // ********************
    initial begin
        {bus, req, ext, trap, disi, take, wait_n, ret} = '0;
        reset_i = 1'b1;
        repeat (12) @(posedge clk_i);
        reset_i <= 1'b0;
        foreach (rst_addr[i]) rd(rst_addr[i], 16'h0000);
        disi <= 1'b1;
        rd(`VPI_OFF_GC2, 16'h4000);
        disi <= 1'b0;
        // Edge polarity: rising first, then falling once selected.
        ext[0] <= 1'b1;
        repeat (3) @(posedge clk_i);
        rd(`VPI_OFF_FLAG, 16'h0001);
        wr(`VPI_OFF_FLAG, 16'h0000);
        wr(`VPI_OFF_GC2, 16'h0001);
        ext[0] <= 1'b0;
        repeat (3) @(posedge clk_i);
        rd(`VPI_OFF_FLAG, 16'h0001);
        wr(`VPI_OFF_FLAG, 16'h0000);
        wr(`VPI_OFF_GC2, 16'h0000);
        pulse_req(17);
        rd(`VPI_OFF_FLAG + 6'h01, 16'h0002);
        wr(`VPI_OFF_FLAG + 6'h01, 16'h0000);
        rd(`VPI_OFF_FLAG + 6'h01, 16'h0000);
        // Requests 1 and 3 at priority 5.
        wr(`VPI_OFF_EN, 16'h000a);
        wr(`VPI_OFF_PRIO, 16'h5050);
        pulse_req(3);
        wait_irq(1'b1);
        chk({17'h0, irq.vector}, 24'h00000b);
        chk(irq.addr, 24'h00001a);
        rd(`VPI_OFF_PEND, 16'h050b);
        wr(`VPI_OFF_GC2, 16'h8000);
        repeat (2) @(posedge clk_i);
        #1;
        chk(irq.addr, 24'h00011a);
        wr(`VPI_OFF_GC2, 16'h0000);
        wr(`VPI_OFF_STATUS, 16'h00a0);
        wait_irq(1'b0);
        rd(`VPI_OFF_STATUS, 16'h00a0);
        wr(`VPI_OFF_STATUS, 16'h0080);
        wait_irq(1'b1);
        wr(`VPI_OFF_STATUS, 16'h00e0);
        wait_irq(1'b0);
        wr(`VPI_OFF_STATUS, 16'h0000);
        pulse_req(1);
        repeat (3) @(posedge clk_i);
        #1;
        chk({17'h0, irq.vector}, 24'h000009);
        grab(4'h3);
        chk({20'h0, lvl}, 24'h000005);
        chk({17'h0, f_vec}, 24'h000009);
        wr(`VPI_OFF_FLAG, 16'h0000);
        // Request 71 at priority 7 pre-empts the running level 5.
        wr(`VPI_OFF_EN + 6'h04, 16'h0080);
        wr(`VPI_OFF_PRIO + 6'h11, 16'h7000);
        pulse_req(71);
        wait_irq(1'b1);
        chk(irq.addr, 24'h0000a2);
        grab(4'h0);
        chk({20'h0, lvl}, 24'h000007);
        give_back(4'h5);
        wr(`VPI_OFF_FLAG + 6'h04, 16'h0000);
        // Nesting disabled: level frozen, accept raises it to 7.
        wr(`VPI_OFF_GC1, 16'h8000);
        wr(`VPI_OFF_STATUS, 16'h0020);
        rd(`VPI_OFF_STATUS, 16'h00a0);
        wr(`VPI_OFF_PRIO + 6'h11, 16'h6000);
        pulse_req(71);
        wait_irq(1'b1);
        grab(4'h0);
        chk({20'h0, lvl}, 24'h000007);
        give_back(4'h5);
        wr(`VPI_OFF_FLAG + 6'h04, 16'h0000);
        wr(`VPI_OFF_GC1, 16'h0000);
        wr(`VPI_OFF_CORE, 16'h0008);
        rd(`VPI_OFF_CORE, 16'h0000);
        // A trap beats a pending user request.
        pulse_req(71);
        @(posedge clk_i);
        trap <= 8'h02;
        @(posedge clk_i);
        trap <= 8'h00;
        repeat (3) @(posedge clk_i);
        #1;
        chk({17'h0, irq.vector}, 24'h000001);
        chk({20'h0, irq.level}, 24'h00000e);
        chk(irq.addr, 24'h000006);
        rd(`VPI_OFF_GC1, 16'h0002);
        grab(4'h0);
        rd(`VPI_OFF_CORE, 16'h0008);
        rd(`VPI_OFF_STATUS, 16'h00c0);
        wr(`VPI_OFF_GC1, 16'h0000);
        wr(`VPI_OFF_CORE, 16'h0000);
        rd(`VPI_OFF_CORE, 16'h0000);
        wait_irq(1'b0);
        report_and_stop();
    end
endmodule : tb_top
